// ==== halt_request_enable_logic.sv ====
// Our own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/100ps
`include "halt_request_enable_map.svh"

module halt_request_enable_logic #(
  parameter int CH = 3
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [3:0] awaddr,
  // AXI4-Lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [3:0] araddr,
  // AXI4-Lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Core and background controller side
  input wire halt_request_enable_pkg::halt_request_enable_core_in_type core_in,
  output halt_request_enable_pkg::halt_request_enable_out_type brk_out
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic aw_got;
    logic [3:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    halt_request_enable_pkg::halt_request_enable_ctrl_type ctrl;
    logic [11:0] sequencer_state_ctrl;
    halt_request_enable_pkg::halt_request_enable_seq_type seq;
    logic [1:0] level;
    logic [1:0] win_ch;
    logic pend;
    logic forced;
    halt_request_enable_pkg::halt_request_enable_out_type outs;
  } halt_request_enable_state_type;

  halt_request_enable_state_type r;
  halt_request_enable_state_type next_r;

  // Decoded helpers shared with checks
  logic wr_do;
  logic force_evt;
  logic [CH-1:0] evt;
  logic [CH-1:0] fin_hits;
  logic trigger;
  logic route_ok;
  logic route_bdm;
  logic suppress;

  // ----------------------------------------
  // Handshake outputs
  // ----------------------------------------
  assign awready = !r.aw_got;
  assign wready = !r.w_got;
  assign arready = !r.rvalid;
  assign bvalid = r.bvalid;
  assign bresp = r.bresp;
  assign rvalid = r.rvalid;
  assign rdata = r.rdata;
  assign rresp = r.rresp;
  assign brk_out = r.outs;

  // Write performed once address and data are both held
  assign wr_do = r.aw_got && r.w_got && !r.bvalid;
  assign force_evt = wr_do && (r.aw_addr == `HALT_REQUEST_ENABLE_OFS_CTRL) && r.w_strb[0]
    && r.w_data[`HALT_REQUEST_ENABLE_CTRL_FORCE] && r.w_data[`HALT_REQUEST_ENABLE_CTRL_ARM];

  // Channel events, tagged or immediate
  always_comb begin
    for (int i = 0; i < CH; i++) begin
      evt[i] = (r.ctrl.tag_sel[i] ? (core_in.tag_hit[i] && !core_in.bdm_single_step)
                : core_in.chan_match[i]) && !core_in.bdm_active;
      // fourth bit marks a Final transition
      fin_hits[i] = evt[i] && r.sequencer_state_ctrl[i*`HALT_REQUEST_ENABLE_SCR_W + `HALT_REQUEST_ENABLE_SCR_EXT];
    end
  end

  // an armed sequencer reacts to Final hits or force, a disarmed one to force only
  // arm plus force from disarmed triggers in one write
  assign trigger = ((r.seq == halt_request_enable_pkg::SEQ_ARMED) && (force_evt || (|fin_hits)))
    || ((r.seq == halt_request_enable_pkg::SEQ_DISARMED) && force_evt);

  assign route_ok = r.pend && r.ctrl.halt_request_enable && !core_in.bdm_active;
  assign route_bdm = route_ok && r.ctrl.target_bdm && core_in.bdm_enable;
  // forced interrupt break yields to background insn
  assign suppress = r.pend && r.forced && core_in.background_insn_exec && core_in.bdm_enable
    && !route_bdm;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_r = r;
    next_r.outs.trace_start = 1'b0;
    next_r.outs.trace_stop = 1'b0;
    next_r.outs.resume_next = 1'b0;
    next_r.outs.defer_swi = 1'b0;

    // Write channel capture
    if (awvalid && !r.aw_got) begin
      next_r.aw_got = 1'b1;
      next_r.aw_addr = awaddr;
    end
    if (wvalid && !r.w_got) begin
      next_r.w_got = 1'b1;
      next_r.w_data = wdata;
      next_r.w_strb = wstrb;
    end
    if (r.bvalid && bready) begin
      next_r.bvalid = 1'b0;
    end

    // Register write
    if (wr_do) begin
      next_r.aw_got = 1'b0;
      next_r.w_got = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = `HALT_REQUEST_ENABLE_RESP_OKAY;
      unique case (r.aw_addr)
        `HALT_REQUEST_ENABLE_OFS_CTRL: begin
          if (r.w_strb[0]) begin
            next_r.ctrl.arm = r.w_data[`HALT_REQUEST_ENABLE_CTRL_ARM];
            next_r.ctrl.capture_source_sel = r.w_data[`HALT_REQUEST_ENABLE_CTRL_SRC];
            next_r.ctrl.trace_alignment_sel = r.w_data[`HALT_REQUEST_ENABLE_CTRL_ALIGN];
            next_r.ctrl.target_bdm = r.w_data[`HALT_REQUEST_ENABLE_CTRL_TGT];
            next_r.ctrl.immediate_halt_bit = r.w_data[`HALT_REQUEST_ENABLE_CTRL_HALT];
            next_r.ctrl.halt_request_enable = r.w_data[`HALT_REQUEST_ENABLE_CTRL_HRE];
          end
          if (r.w_strb[1]) begin
            next_r.ctrl.tag_sel = r.w_data[`HALT_REQUEST_ENABLE_CTRL_TAG_HI:`HALT_REQUEST_ENABLE_CTRL_TAG_LO];
          end
        end
        `HALT_REQUEST_ENABLE_OFS_SCR: begin
          if (r.w_strb[0]) begin
            next_r.sequencer_state_ctrl[7:0] = r.w_data[7:0];
          end
          if (r.w_strb[1]) begin
            next_r.sequencer_state_ctrl[11:8] = r.w_data[11:8];
          end
        end
        `HALT_REQUEST_ENABLE_OFS_STAT: begin
          next_r.bresp = `HALT_REQUEST_ENABLE_RESP_OKAY;
        end
        default: begin
          next_r.bresp = `HALT_REQUEST_ENABLE_RESP_SLVERR;
        end
      endcase
    end

    // Register read
    if (r.rvalid && rready) begin
      next_r.rvalid = 1'b0;
    end
    if (arvalid && !r.rvalid) begin
      next_r.rvalid = 1'b1;
      next_r.rresp = `HALT_REQUEST_ENABLE_RESP_OKAY;
      next_r.rdata = 32'h0000_0000;
      unique case (araddr)
        `HALT_REQUEST_ENABLE_OFS_CTRL: begin
          next_r.rdata[`HALT_REQUEST_ENABLE_CTRL_ARM] = r.ctrl.arm;
          next_r.rdata[`HALT_REQUEST_ENABLE_CTRL_SRC] = r.ctrl.capture_source_sel;
          next_r.rdata[`HALT_REQUEST_ENABLE_CTRL_ALIGN] = r.ctrl.trace_alignment_sel;
          next_r.rdata[`HALT_REQUEST_ENABLE_CTRL_TGT] = r.ctrl.target_bdm;
          next_r.rdata[`HALT_REQUEST_ENABLE_CTRL_HALT] = r.ctrl.immediate_halt_bit;
          next_r.rdata[`HALT_REQUEST_ENABLE_CTRL_HRE] = r.ctrl.halt_request_enable;
          next_r.rdata[`HALT_REQUEST_ENABLE_CTRL_TAG_HI:`HALT_REQUEST_ENABLE_CTRL_TAG_LO] = r.ctrl.tag_sel;
        end
        `HALT_REQUEST_ENABLE_OFS_STAT: begin
          next_r.rdata[7:0] = {r.forced, r.pend, r.win_ch, r.level, r.seq};
        end
        `HALT_REQUEST_ENABLE_OFS_SCR: begin
          next_r.rdata[11:0] = r.sequencer_state_ctrl;
        end
        default: begin
          next_r.rresp = `HALT_REQUEST_ENABLE_RESP_SLVERR;
        end
      endcase
    end

    // Sequencer arming and disarming
    if (!r.ctrl.arm) begin
      next_r.seq = halt_request_enable_pkg::SEQ_DISARMED;
    end else if (r.seq == halt_request_enable_pkg::SEQ_DISARMED) begin
      next_r.seq = halt_request_enable_pkg::SEQ_ARMED;
      next_r.level = 2'h0;
    end

    // Final hits first, then lowest channel
    if (r.seq == halt_request_enable_pkg::SEQ_ARMED && !force_evt) begin
      if (|fin_hits) begin
        for (int i = CH - 1; i >= 0; i--) begin
          if (fin_hits[i]) begin
            next_r.win_ch = i[1:0];
          end
        end
      end else if (|evt) begin
        for (int i = CH - 1; i >= 0; i--) begin
          if (evt[i]) begin
            next_r.win_ch = i[1:0];
            next_r.level = i[1:0] + 2'h1;
          end
        end
      end
    end

    // Acknowledged request retires
    if (r.pend && core_in.brk_taken) begin
      next_r.pend = 1'b0;
    end
    if (suppress) begin
      next_r.pend = 1'b0;
    end

    if (trigger) begin
      next_r.forced = force_evt;
      if (force_evt) begin
        next_r.win_ch = `HALT_REQUEST_ENABLE_CH_NONE;
      end
      // Settings of a same-cycle control write apply to its own force
      if (next_r.ctrl.immediate_halt_bit) begin
        next_r.outs.trace_stop = 1'b1;
        next_r.pend = next_r.ctrl.halt_request_enable;
        next_r.seq = halt_request_enable_pkg::SEQ_DISARMED;
        next_r.ctrl.arm = 1'b0;
      end else if (!next_r.ctrl.capture_source_sel) begin
        next_r.pend = next_r.ctrl.halt_request_enable;
        next_r.seq = halt_request_enable_pkg::SEQ_DISARMED;
        next_r.ctrl.arm = 1'b0;
      end else if (!next_r.ctrl.trace_alignment_sel) begin
        next_r.outs.trace_stop = 1'b1;
        next_r.pend = next_r.ctrl.halt_request_enable;
        next_r.seq = halt_request_enable_pkg::SEQ_DISARMED;
        next_r.ctrl.arm = 1'b0;
      end else begin
        next_r.outs.trace_start = 1'b1;
        next_r.seq = halt_request_enable_pkg::SEQ_TRACING;
      end
    end

    // later force has no effect here
    if (r.seq == halt_request_enable_pkg::SEQ_TRACING && r.ctrl.arm && core_in.trace_done) begin
      next_r.pend = r.ctrl.halt_request_enable;
      next_r.seq = halt_request_enable_pkg::SEQ_DISARMED;
      next_r.ctrl.arm = 1'b0;
    end

    // pending request held while background is active
    next_r.outs.brk_bdm = route_bdm;
    next_r.outs.brk_swi = route_ok && !route_bdm && !suppress;
    // user interrupt insn waits for background
    next_r.outs.defer_swi = route_bdm && core_in.swi_exec;
    next_r.outs.resume_next = r.pend && core_in.background_insn_exec;
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
      r.sequencer_state_ctrl <= `HALT_REQUEST_ENABLE_SCR_RST;
      r.win_ch <= `HALT_REQUEST_ENABLE_CH_NONE;
      r.seq <= halt_request_enable_pkg::SEQ_DISARMED;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_begin_software_force_bit;
    trigger && r.ctrl.capture_source_sel && r.ctrl.trace_alignment_sel
      && !r.ctrl.immediate_halt_bit;
  endsequence

  sequence s_trace_open;
    r.outs.trace_start && (r.seq == halt_request_enable_pkg::SEQ_TRACING);
  endsequence

  chk_begin_start: assert property (s_begin_software_force_bit |=> s_trace_open)
    else $error("begin alignment did not start tracing");

  chk_trace_wait: assert property (
    (r.seq == halt_request_enable_pkg::SEQ_TRACING) && !core_in.trace_done && !wr_do
      |=> (r.seq == halt_request_enable_pkg::SEQ_TRACING) && !$rose(r.pend))
    else $error("breakpoint before trace completion");

  chk_halt_now: assert property (
    trigger && r.ctrl.immediate_halt_bit && r.ctrl.halt_request_enable
      |=> r.pend && r.outs.trace_stop)
    else $error("immediate halt did not request breakpoint");

  chk_end_disarm: assert property (
    trigger && r.ctrl.capture_source_sel && !r.ctrl.trace_alignment_sel
      && !r.ctrl.immediate_halt_bit && !r.ctrl.halt_request_enable
      |=> !r.pend && r.outs.trace_stop && !r.ctrl.arm)
    else $error("end alignment without halt enable misbehaved");

  chk_bdm_mask: assert property (
    core_in.bdm_active |=> !brk_out.brk_swi && !brk_out.brk_bdm)
    else $error("breakpoint while background active");

  chk_no_enable: assert property (
    !r.ctrl.halt_request_enable |=> !brk_out.brk_swi && !brk_out.brk_bdm)
    else $error("breakpoint without halt enable");

  chk_bdm_route: assert property (
    route_ok && r.ctrl.target_bdm && core_in.bdm_enable
      |=> brk_out.brk_bdm && !brk_out.brk_swi)
    else $error("background route not taken");

  chk_swi_suppress: assert property (
    suppress |=> !brk_out.brk_swi ##1 !r.pend)
    else $error("software interrupt break not suppressed");

  chk_swi_defer: assert property (
    route_bdm && core_in.swi_exec |=> brk_out.defer_swi && brk_out.brk_bdm)
    else $error("user interrupt insn not deferred");

  chk_tag_step: assert property (
    core_in.bdm_single_step |-> !(|(evt & r.ctrl.tag_sel)))
    else $error("tag taken during single step");

  chk_pend_hold: assert property (
    r.pend && core_in.bdm_active && !core_in.brk_taken && !trigger
      && !core_in.background_insn_exec |=> r.pend)
    else $error("pending breakpoint lost in background");

endmodule : halt_request_enable_logic

// ==== halt_request_enable_map.svh ====
`ifndef HALT_REQUEST_ENABLE_MAP_SVH
`define HALT_REQUEST_ENABLE_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define HALT_REQUEST_ENABLE_OFS_CTRL 4'h0
`define HALT_REQUEST_ENABLE_OFS_STAT 4'h4
`define HALT_REQUEST_ENABLE_OFS_SCR 4'h8

// ----------------------------------------
// debug_control_one field positions
// ----------------------------------------
`define HALT_REQUEST_ENABLE_CTRL_ARM 0
`define HALT_REQUEST_ENABLE_CTRL_FORCE 1
`define HALT_REQUEST_ENABLE_CTRL_SRC 2
`define HALT_REQUEST_ENABLE_CTRL_ALIGN 3
`define HALT_REQUEST_ENABLE_CTRL_TGT 4
`define HALT_REQUEST_ENABLE_CTRL_HALT 5
`define HALT_REQUEST_ENABLE_CTRL_HRE 6
`define HALT_REQUEST_ENABLE_CTRL_TAG_LO 8
`define HALT_REQUEST_ENABLE_CTRL_TAG_HI 10

// ----------------------------------------
// sequencer_state_ctrl layout and resets
// ----------------------------------------
`define HALT_REQUEST_ENABLE_SCR_W 4
`define HALT_REQUEST_ENABLE_SCR_EXT 3
`define HALT_REQUEST_ENABLE_SCR_RST 12'h000
`define HALT_REQUEST_ENABLE_CH_NONE 2'h3

// ----------------------------------------
// Bus answers
// ----------------------------------------
`define HALT_REQUEST_ENABLE_RESP_OKAY 2'h0
`define HALT_REQUEST_ENABLE_RESP_SLVERR 2'h2

`endif

// ==== halt_request_enable_pkg.sv ====
package halt_request_enable_pkg;

  // Sequencer progress
  typedef enum logic [1:0] {
    SEQ_DISARMED,
    SEQ_ARMED,
    SEQ_TRACING
  } halt_request_enable_seq_type;

  // Software control bits
  typedef struct packed {
    logic arm;
    logic capture_source_sel;
    logic trace_alignment_sel;
    logic target_bdm;
    logic immediate_halt_bit;
    logic halt_request_enable;
    logic [2:0] tag_sel;
  } halt_request_enable_ctrl_type;

  // Core, trace and background controller inputs
  typedef struct packed {
    logic [2:0] chan_match;
    logic [2:0] tag_hit;
    logic trace_done;
    logic bdm_active;
    logic bdm_enable;
    logic bdm_single_step;
    logic background_insn_exec;
    logic swi_exec;
    logic brk_taken;
  } halt_request_enable_core_in_type;

  // Breakpoint and trace outputs
  typedef struct packed {
    logic brk_swi;
    logic brk_bdm;
    logic trace_start;
    logic trace_stop;
    logic resume_next;
    logic defer_swi;
  } halt_request_enable_out_type;

endpackage : halt_request_enable_pkg

// ==== halt_request_enable_core_model.sv ====
`timescale 1ns/100ps
module halt_request_enable_core_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Breakpoint link
  input wire halt_request_enable_pkg::halt_request_enable_out_type brk_out,
  output logic brk_taken,
  // Bench control
  input wire logic take_en,
  input wire logic slow
);
  logic [2:0] wait_cnt;

  // Core accepts a request after a short or long delay
  always @(posedge aclk) begin
    brk_taken <= 1'b0;
    if (!aresetn || !take_en || !(brk_out.brk_swi || brk_out.brk_bdm) || brk_taken) begin
      wait_cnt <= 3'h0;
    end else if (wait_cnt == (slow ? 3'h4 : 3'h1)) begin
      brk_taken <= 1'b1;
      wait_cnt <= 3'h0;
    end else begin
      wait_cnt <= wait_cnt + 3'h1;
    end
  end
endmodule : halt_request_enable_core_model

// ==== tb_top.sv ====
`timescale 1ns/100ps
`include "halt_request_enable_map.svh"
module tb_top;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, take_en, slow;
  logic awready, wready, bvalid, arready, rvalid, taken;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp, rsp;
  logic [5:0] seen;
  int err_total, cmp_count, cyc;
  halt_request_enable_pkg::halt_request_enable_core_in_type ci, core_v;
  halt_request_enable_pkg::halt_request_enable_out_type brk_out;
  localparam logic [5:0] SOFTWARE_INTERRUPT_INSN = 6'h20, BACKGROUND_DEBUG_MODE = 6'h10, TST = 6'h08, TSP = 6'h04;
  localparam logic [5:0] RES = 6'h02, DFR = 6'h01;

  halt_request_enable_logic dut_u (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .core_in(core_v), .brk_out(brk_out));
  halt_request_enable_core_model core_u (.aclk(aclk), .aresetn(aresetn), .brk_out(brk_out),
    .brk_taken(taken), .take_en(take_en), .slow(slow));

  // Core inputs with the partner's acceptance merged in
  always_comb begin
    core_v = ci;
    core_v.brk_taken = taken;
  end

  // Clock
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  // Hang guard
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      final_report();
    end
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    bit ad, wd;
    ad = 0;
    wd = 0;
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hF;
    bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        ad = 1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        wd = 1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rdr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge aclk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rdr

  task automatic rst();
    @(posedge aclk);
    aresetn <= 1'b0;
    ci <= '0;
    take_en <= 1'b1;
    slow <= 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
  endtask : rst

  task automatic arm(input logic [31:0] c, input logic [31:0] sequencer_state_ctrl);
    wr(`HALT_REQUEST_ENABLE_OFS_SCR, sequencer_state_ctrl, rsp);
    wr(`HALT_REQUEST_ENABLE_OFS_CTRL, c, rsp);
    repeat (2) @(posedge aclk);
  endtask : arm

  task automatic ev(input logic [2:0] m, input logic [2:0] t, input logic [2:0] tsb);
    @(posedge aclk);
    ci.chan_match <= m;
    ci.tag_hit <= t;
    {ci.trace_done, ci.swi_exec, ci.background_insn_exec} <= tsb;
    @(posedge aclk);
    ci.chan_match <= 3'h0;
    ci.tag_hit <= 3'h0;
    {ci.trace_done, ci.swi_exec, ci.background_insn_exec} <= 3'h0;
  endtask : ev

  task automatic watch(input int n);
    seen = '0;
    repeat (n) begin
      @(posedge aclk);
      seen = seen | brk_out;
    end
  endtask : watch

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    rst();
    for (int k = 0; k < 3; k++) begin
      rdr(4'(4 * k), rd, rsp);
      chk(rd, (k == 1) ? {26'h0, `HALT_REQUEST_ENABLE_CH_NONE, 4'h0} : 32'h0);
      chk(rsp, `HALT_REQUEST_ENABLE_RESP_OKAY);
    end
    wr(`HALT_REQUEST_ENABLE_OFS_SCR, 32'h0000_0FFF, rsp);
    chk(rsp, `HALT_REQUEST_ENABLE_RESP_OKAY);
    rdr(`HALT_REQUEST_ENABLE_OFS_SCR, rd, rsp);
    chk(rd, 32'h0000_0FFF);
    rdr(4'hC, rd, rsp);
    chk(rd, 32'h0);
    chk(rsp, `HALT_REQUEST_ENABLE_RESP_SLVERR);
    wr(4'hC, 32'h0, rsp);
    chk(rsp, `HALT_REQUEST_ENABLE_RESP_SLVERR);
  endtask : t_regs

  task automatic t_route();
    for (int k = 0; k < 4; k++) begin
      rst();
      slow <= k[0];
      ci.bdm_enable <= (k != 2);
      arm({25'h0, k != 0, 1'b0, k != 1, 4'h1}, 32'h8);
      ev(3'h1, 3'h0, 3'h0);
      watch(10);
      chk(seen & (SOFTWARE_INTERRUPT_INSN | BACKGROUND_DEBUG_MODE), (k == 0) ? 6'h0 : (k == 3) ? BACKGROUND_DEBUG_MODE : SOFTWARE_INTERRUPT_INSN);
    end
  endtask : t_route

  task automatic t_trace();
    rst();
    arm(32'h4D, 32'h8);
    ev(3'h1, 3'h0, 3'h0);
    watch(4);
    chk(seen & (SOFTWARE_INTERRUPT_INSN | BACKGROUND_DEBUG_MODE | TST), TST);
    wr(`HALT_REQUEST_ENABLE_OFS_CTRL, 32'h4F, rsp);
    ev(3'h1, 3'h0, 3'h0);
    watch(4);
    chk(seen & (SOFTWARE_INTERRUPT_INSN | BACKGROUND_DEBUG_MODE), 6'h0);
    ev(3'h0, 3'h0, 3'h4);
    watch(6);
    chk(seen & SOFTWARE_INTERRUPT_INSN, SOFTWARE_INTERRUPT_INSN);
  endtask : t_trace

  task automatic t_align();
    for (int k = 0; k < 4; k++) begin
      rst();
      arm({25'h0, k[0], k[1], 1'b0, k[1], 3'h5}, 32'h8);
      ev(3'h1, 3'h0, 3'h0);
      watch(6);
      chk(seen & (SOFTWARE_INTERRUPT_INSN | TST | TSP), {k[0], 2'h0, 1'b1, 2'h0});
      rdr(`HALT_REQUEST_ENABLE_OFS_STAT, rd, rsp);
      chk(rd[1:0], 2'h0);
    end
  endtask : t_align

  task automatic t_force();
    rst();
    wr(`HALT_REQUEST_ENABLE_OFS_CTRL, 32'h43, rsp);
    watch(6);
    chk(seen & SOFTWARE_INTERRUPT_INSN, SOFTWARE_INTERRUPT_INSN);
  endtask : t_force

  task automatic t_bdm();
    rst();
    ci.bdm_enable <= 1'b1;
    ci.bdm_active <= 1'b1;
    arm(32'h51, 32'h8);
    ev(3'h1, 3'h0, 3'h0);
    ci.bdm_active <= 1'b0;
    watch(6);
    chk(seen & (SOFTWARE_INTERRUPT_INSN | BACKGROUND_DEBUG_MODE), 6'h0);
    arm(32'h151, 32'h8);
    ci.bdm_single_step <= 1'b1;
    ev(3'h0, 3'h1, 3'h0);
    watch(6);
    chk(seen & (SOFTWARE_INTERRUPT_INSN | BACKGROUND_DEBUG_MODE), 6'h0);
    ci.bdm_single_step <= 1'b0;
    ev(3'h1, 3'h0, 3'h0);
    watch(6);
    chk(seen & (SOFTWARE_INTERRUPT_INSN | BACKGROUND_DEBUG_MODE), 6'h0);
    ev(3'h0, 3'h1, 3'h0);
    watch(6);
    chk(seen & (SOFTWARE_INTERRUPT_INSN | BACKGROUND_DEBUG_MODE), BACKGROUND_DEBUG_MODE);
  endtask : t_bdm

  task automatic t_hold();
    rst();
    take_en <= 1'b0;
    ci.bdm_enable <= 1'b1;
    arm(32'h51, 32'h8);
    ev(3'h1, 3'h0, 3'h0);
    ev(3'h0, 3'h0, 3'h2);
    watch(3);
    chk(seen & (BACKGROUND_DEBUG_MODE | DFR), BACKGROUND_DEBUG_MODE | DFR);
    ev(3'h0, 3'h0, 3'h1);
    watch(3);
    chk(seen & RES, RES);
    ci.bdm_active <= 1'b1;
    repeat (3) @(posedge aclk);
    chk(brk_out.brk_bdm, 1'b0);
    ci.bdm_active <= 1'b0;
    watch(4);
    chk(seen & BACKGROUND_DEBUG_MODE, BACKGROUND_DEBUG_MODE);
    take_en <= 1'b1;
    // forced break yields to background insn
    rst();
    take_en <= 1'b0;
    ci.bdm_enable <= 1'b1;
    arm(32'h41, 32'h0);
    wr(`HALT_REQUEST_ENABLE_OFS_CTRL, 32'h43, rsp);
    ev(3'h0, 3'h0, 3'h1);
    repeat (3) @(posedge aclk);
    chk(brk_out.brk_swi, 1'b0);
  endtask : t_hold

  task automatic t_prio();
    rst();
    arm(32'h541, 32'h800);
    ev(3'h0, 3'h5, 3'h0);
    watch(6);
    chk(seen & SOFTWARE_INTERRUPT_INSN, SOFTWARE_INTERRUPT_INSN);
    rdr(`HALT_REQUEST_ENABLE_OFS_STAT, rd, rsp);
    chk(rd[5:4], 2'h2);
    wr(`HALT_REQUEST_ENABLE_OFS_CTRL, 32'h0, rsp);
  endtask : t_prio

  task automatic final_report();
    $display("mismatches %0d, comparisons %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report

  // Main sequence
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wstrb, wdata} = '0;
    ci = '0;
    take_en = 1'b1;
    slow = 1'b0;
    t_regs();
    t_route();
    t_trace();
    t_align();
    t_force();
    t_bdm();
    t_hold();
    t_prio();
    final_report();
  end
endmodule : tb_top
